// file: logic/wois_pkg.sv
// wois_pkg: constants for the write-only serial control port receiver
// assumes: shared by wois_rx and wois_rx_test; no registers reachable by software
package wois_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    // bit count at which the ninth (acknowledge) clock arrives
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [7:0] WORD_RST = 8'h00;
    // own address; value is arbitrary
    localparam logic [6:0] OWN_ADDR_DEF = 7'h2a;
    // highest serial clock rate the master may use, in kHz
    localparam int SCL_MAX_KHZ = 400;
    localparam int REF_CLK_KHZ = 25000;
    // ref_clk cycles in one fastest serial clock period, rounded down
    localparam int SCL_MIN_CYC = REF_CLK_KHZ / SCL_MAX_KHZ;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_IGNR = 4'b1000
    } wois_state_t;
endpackage

// file: logic/wois_rx.sv
// wois_rx: write-only serial slave receiver, serial side clocked by scl_i
// assumes: master drives scl; sda is an open-drain wire resolved outside
// from sda_oe; received words are handed to the ref_clk side by toggle.
`timescale 1ns/1ps

module wois_rx
    import wois_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
) (
    input wire logic ref_clk, // system clock, 25 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire logic ce, // clock enable for the ref_clk side
    input wire logic scl_i, // serial clock from the master
    input wire logic sda_i, // serial data line level
    output logic sda_o, // serial data drive value, always low
    output logic sda_oe, // high while pulling serial data low
    output logic [7:0] rx_data, // last received word
    output logic rx_valid, // one-cycle pulse with a new word
    output logic busy // high from start to stop
);
    // ---------------- start / stop detection on data edges ----------------
    logic start_tgl_q;
    logic stop_tgl_q;

    always_ff @(negedge sda_i or negedge rstn) begin
        if (!rstn) begin
            start_tgl_q <= 1'b0;
        end else if (scl_i) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge sda_i or negedge rstn) begin
        if (!rstn) begin
            stop_tgl_q <= 1'b0;
        end else if (scl_i) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // ---------------- serial side, rising serial clock ----------------
    wois_state_t state_q;
    wois_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] word_q;
    logic word_tgl_q;
    logic start_seen_q;
    logic [7:0] shift_in;
    logic start_pend;
    logic at_ack;
    logic last_bit;
    logic addr_match;
    logic rw_read;

    assign start_pend = start_tgl_q != start_seen_q;
    assign shift_in = {shift_q[6:0], sda_i};
    assign at_ack = cnt_q == ACK_CNT;
    assign last_bit = cnt_q == (ACK_CNT - CNT_ONE);
    assign addr_match = shift_q[7:1] == OWN_ADDR;
    assign rw_read = shift_q[0];

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        if (start_pend) begin
            // first address bit arrives on the first rise after the start
            state_d = ST_ADDR;
            cnt_d = CNT_ONE;
            shift_d = {WORD_RST[6:0], sda_i};
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (at_ack) begin
                        cnt_d = CNT_RST;
                        if (addr_match && !rw_read) begin
                            state_d = ST_DATA;
                        end else begin
                            state_d = ST_IGNR;
                        end
                    end else begin
                        cnt_d = cnt_q + CNT_ONE;
                        shift_d = shift_in;
                    end
                end
                ST_DATA: begin
                    if (at_ack) begin
                        cnt_d = CNT_RST;
                    end else begin
                        cnt_d = cnt_q + CNT_ONE;
                        shift_d = shift_in;
                    end
                end
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
    end

    always_ff @(posedge scl_i or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RST;
            shift_q <= WORD_RST;
            start_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            start_seen_q <= start_tgl_q;
        end
    end

    // word is held stable until the next one is complete
    always_ff @(posedge scl_i or negedge rstn) begin
        if (!rstn) begin
            word_q <= WORD_RST;
            word_tgl_q <= 1'b0;
        end else if (!start_pend && state_q == ST_DATA && last_bit) begin
            word_q <= shift_in;
            word_tgl_q <= ~word_tgl_q;
        end
    end

    // ---------------- acknowledge drive, falling serial clock ----------------
    logic ack_due;
    logic ack_q;
    logic drive_q;

    // after the eighth rise the ninth clock is next: pull low across it
    assign ack_due = at_ack && !start_pend
                     && ((state_q == ST_ADDR && addr_match && !rw_read)
                         || state_q == ST_DATA);

    always_ff @(negedge scl_i or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            ack_q <= ack_due;
            drive_q <= 1'b0;
        end
    end

    assign sda_oe = ack_q;
    assign sda_o = drive_q;

    // ---------------- ref_clk side ----------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [2:0] word_sync_q;
    logic [2:0] start_sync_q;
    logic [2:0] stop_sync_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic busy_q;
    logic word_evt;
    logic start_evt;
    logic stop_evt;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_sync_q <= 3'b000;
            start_sync_q <= 3'b000;
            stop_sync_q <= 3'b000;
        end else if (ce) begin
            word_sync_q <= {word_sync_q[1:0], word_tgl_q};
            start_sync_q <= {start_sync_q[1:0], start_tgl_q};
            stop_sync_q <= {stop_sync_q[1:0], stop_tgl_q};
        end
    end

    assign word_evt = word_sync_q[2] != word_sync_q[1];
    assign start_evt = start_sync_q[2] != start_sync_q[1];
    assign stop_evt = stop_sync_q[2] != stop_sync_q[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_q <= WORD_RST;
            rx_valid_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce) begin
            rx_valid_q <= word_evt;
            if (word_evt) begin
                rx_data_q <= word_q;
            end
            if (start_evt) begin
                busy_q <= 1'b1;
            end else if (stop_evt) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign busy = busy_q;
endmodule

// file: testbench/wois_rx_monitor.sv
// wois_rx_monitor: concurrent checks on the receiver ports
// assumes: bound to wois_rx; sda_i is the resolved open-drain wire
`timescale 1ns/1ps
module wois_rx_monitor (
    input wire logic ref_clk, // system clock
    input wire logic rstn, // reset, active low
    input wire logic ce, // clock enable
    input wire logic scl_i, // serial clock
    input wire logic sda_i, // serial data wire
    input wire logic sda_o, // data drive value
    input wire logic sda_oe, // data pull enable
    input wire logic [7:0] rx_data, // received word
    input wire logic rx_valid, // word strobe
    input wire logic busy // transfer open
);
    sequence s_ack;
        sda_oe ##1 !sda_oe;
    endsequence
    a_drive_low: assert property (@(posedge ref_clk) sda_o == 1'b0)
        else $error("data drive value not low");
    a_ack_one_clock: assert property (@(negedge scl_i) disable iff (!rstn) sda_oe |-> s_ack)
        else $error("ack held longer than one serial clock");
    a_valid_pulse: assert property (@(posedge ref_clk) disable iff (!rstn) rx_valid |=> !rx_valid)
        else $error("word strobe longer than one cycle");
    a_word_strobe: assert property (@(posedge ref_clk) disable iff (!rstn) $changed(rx_data) |-> rx_valid)
        else $error("word changed without strobe");
    a_valid_framed: assert property (@(posedge ref_clk) disable iff (!rstn) rx_valid |-> busy)
        else $error("word outside a transfer");
    a_idle_released: assert property (@(posedge ref_clk) disable iff (!rstn) !busy |-> !sda_oe)
        else $error("data pulled outside a transfer");
    a_reset_quiet: assert property (@(posedge ref_clk) !rstn |-> !sda_oe && !busy && !rx_valid)
        else $error("outputs active in reset");
endmodule

// file: testbench/wois_master.sv
// wois_master: behavioural bus master that bit-bangs scl and pulls sda
// assumes: the bench resolves sda with a pull-up; 48 ns serial clock
`timescale 1ns/1ps
module wois_master (
    output logic scl, // serial clock, idles high between frames
    output logic pull, // high while pulling sda low
    input wire logic sda // resolved sda level
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic start();
        #12 pull = 1'b0;
        #12 scl = 1'b1;
        #24 pull = 1'b1;
        #24 scl = 1'b0;
    endtask
    task automatic stop();
        #12 pull = 1'b1;
        #12 scl = 1'b1;
        #24 pull = 1'b0;
        #24;
    endtask
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            #12 pull = (i >= 0) ? !b[i] : 1'b0;
            #12 scl = 1'b1;
            ack = !sda;
            #24 scl = 1'b0;
        end
    endtask
endmodule

// file: testbench/wois_rx_test.sv
// wois_rx_test: self-checking bench for the serial receiver
// assumes: wois_master drives scl and pulls sda; sda has a pull-up
`timescale 1ns/1ps
module wois_rx_test;
    import wois_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b1;
    logic ce = 1'b1;
    logic scl, pull, sda_oe, rx_valid, busy;
    logic [7:0] rx_data;
    wire logic sda = !(pull === 1'b1 || sda_oe === 1'b1);
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    wois_master m (.scl(scl), .pull(pull), .sda(sda));
    wois_rx dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic frame(input logic [7:0] a, input int n, input bit rs);
        logic ack;
        logic [7:0] w;
        logic ok;
        ok = (a == {OWN_ADDR_DEF, 1'b0});
        m.start();
        m.xfer(a, ack);
        check(ack === ok, "address ack");
        check(busy === 1'b1, "busy after start");
        repeat (n) begin
            w = 8'($urandom);
            if (ok)
                exp_q.push_back(w);
            m.xfer(w, ack);
            check(ack === ok, "data ack");
        end
        if (!rs)
            m.stop();
    endtask
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            check(exp_q.size() > 0 && rx_data === exp_q[0], "wrong word");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        logic [6:0] x;
        void'($urandom(68804));
        // a real falling edge so the serial-side flops clear as well
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #7;
        frame({OWN_ADDR_DEF, 1'b0}, 3, 1'b0);
        frame({OWN_ADDR_DEF, 1'b1}, 1, 1'b1);
        frame({OWN_ADDR_DEF, 1'b0}, 1, 1'b0);
        x = 7'($urandom_range(127, 1));
        frame({OWN_ADDR_DEF ^ x, 1'b0}, 2, 1'b0);
        frame({OWN_ADDR_DEF, 1'b0}, 1, 1'b0);
        repeat (8) @(posedge ref_clk);
        check(exp_q.size() == 0, "words missing");
        check(busy === 1'b0, "busy after stop");
        print_verdict();
    end
endmodule
bind wois_rx wois_rx_monitor mon (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid),
    .busy(busy));
